// ===== src/pwm_pkg.sv
package pwm_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_DUTY_LOW    = 3'h0; // duty high eight bits
  localparam logic [2:0] ADDR_DUTY_SHADOW = 3'h1; // buffered duty, writable outside pwm mode
  localparam logic [2:0] ADDR_CTRL        = 3'h2; // mode and duty lsbs
  localparam logic [2:0] ADDR_PERIOD      = 3'h3; // period register
  localparam logic [2:0] ADDR_TCOUNT      = 3'h4; // timer count
  localparam logic [2:0] ADDR_TCTRL       = 3'h5; // timer control

  // control register field positions
  localparam int CTRL_LSB_POS  = 4; // duty lsbs at 5:4
  localparam int CTRL_MODE_POS = 0; // mode select at 3:0
  localparam int TCTRL_ON_POS  = 2; // timer enable
  localparam int TCTRL_PS_POS  = 0; // prescaler select at 1:0

  // reset values
  localparam logic [7:0] RST_DUTY   = 8'h00; // duty registers
  localparam logic [7:0] RST_CTRL   = 8'h00; // control register
  localparam logic [7:0] RST_PERIOD = 8'hff; // period register
  localparam logic [7:0] RST_TCTRL  = 8'h00; // timer control

  // bit masks
  localparam logic [7:0] CTRL_MASK  = 8'h3f; // top two bits unimplemented
  localparam logic [7:0] TCTRL_MASK = 8'h7f; // top bit unimplemented

  // prescaler ratios
  typedef enum logic [1:0] {
    PWM_PS_1  = 2'h0,
    PWM_PS_4  = 2'h1,
    PWM_PS_16 = 2'h2,
    PWM_PS_16B = 2'h3
  } pwm_ps_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr; // register index
    logic [7:0] wdata; // write data
    logic       wr;    // write strobe
    logic       rd;    // read strobe
  } pwm_req_t;

endpackage : pwm_pkg

// ===== src/pwm_prescaler.sv
`timescale 1ns/1ns
// divides the clock by 1, 4 or 16, provides the two fine duty bits
module pwm_prescaler (
  input  wire logic        i_clock,  // core clock
  input  wire logic        i_nrst,   // sync reset, low
  input  wire logic        i_run,    // timer running
  input  wire logic [1:0]  i_ps,     // prescaler select
  output logic             o_tick,   // one cycle per timer step
  output logic [1:0]       o_fine    // two low bits of time base
);
  import pwm_pkg::*;

  logic [3:0] cnt_ff;  // free count inside one timer step
  logic [3:0] nxt_cnt; // next count
  logic [3:0] lim;     // last count value of a step

  // terminal count per ratio
  always_comb begin
    unique case (pwm_ps_t'(i_ps))
      PWM_PS_1:  lim = 4'h0;
      PWM_PS_4:  lim = 4'h3;
      PWM_PS_16: lim = 4'hf;
      PWM_PS_16B: lim = 4'hf;
    endcase
    nxt_cnt = (cnt_ff >= lim) ? 4'h0 : cnt_ff + 4'h1;
  end

  // counter, cleared while stopped
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !i_run) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_tick = i_run && (cnt_ff >= lim);

  // fine bits: the top two prescaler bits, or zero at 1:1
  always_comb begin
    unique case (pwm_ps_t'(i_ps))
      PWM_PS_1:  o_fine = 2'h0;
      PWM_PS_4:  o_fine = cnt_ff[1:0];
      PWM_PS_16: o_fine = cnt_ff[3:2];
      PWM_PS_16B: o_fine = cnt_ff[3:2];
    endcase
  end

endmodule : pwm_prescaler

// ===== src/pwm_channel.sv
`timescale 1ns/1ns
// Operation
// RULE_01: pwm output with ten bit duty
// RULE_02: software clears pin direction to drive
// RULE_03: control write zero forces output low
// RULE_04: period register sets the period
// RULE_05: count equal period clears count next
// RULE_06: restart sets pin unless duty zero
// RULE_07: restart copies duty low into shadow
// RULE_08: postscaler does not affect pwm period
// RULE_09: duty is low reg plus ctrl 5:4
// RULE_10: duty writes apply after period ends
// RULE_11: shadow ignores writes in pwm mode
// RULE_12: shadow plus two bit latch buffer
// RULE_13: clear pin on ten bit match
// RULE_14: duty beyond period keeps pin high
// RULE_15: prescaler ratios one, four, sixteen
// RULE_16: control top two bits read zero
// RULE_17: software setup order period duty pin timer
// RULE_18: mode bits 11xx select pwm
module pwm_channel (
  input  wire logic             i_clock,  // 10 MHz core clock
  input  wire logic             i_nrst,   // sync reset, low
  input  wire pwm_pkg::pwm_req_t i_req,   // register request
  input  wire logic             i_dir_in, // pin direction bit, 1 input
  output logic [7:0]            o_rdata,  // read data, cycle after read
  output logic                  o_pwm,    // output latch level
  output logic                  o_pwm_oe  // pin driver enable
);
  import pwm_pkg::*;

  // software registers
  logic [7:0] duty_low_ff;   // duty high eight bits as written
  logic [7:0] shadow_ff;     // buffered duty high bits
  logic [1:0] lsb_latch_ff;  // buffered duty low bits
  logic [7:0] ctrl_ff;       // mode and duty lsbs
  logic [7:0] period_ff;     // period register
  logic [7:0] tcount_ff;     // timer count
  logic [7:0] tctrl_ff;      // timer control
  logic       out_ff;        // output latch
  logic       oe_ff;         // registered driver enable
  logic [7:0] rdata_ff;      // registered read data

  // derived
  logic       pwm_mode;      // pwm mode selected
  logic       tick;          // timer step
  logic [1:0] fine;          // two fine time base bits
  logic       restart;       // count reaches period on a step
  logic [9:0] base10;        // extended time base
  logic [9:0] duty10;        // buffered ten bit duty
  logic       wr_ctrl;       // write to control
  logic [7:0] nxt_tcount;    // next timer count
  logic       nxt_out;       // next output level

  // decode a write to one register
  function automatic logic is_wr(input pwm_req_t r, input logic [2:0] a);
    is_wr = r.wr && (r.addr == a);
  endfunction : is_wr

  assign pwm_mode = (ctrl_ff[CTRL_MODE_POS+3 -: 2] == 2'h3); // [RULE_18]
  assign wr_ctrl  = is_wr(i_req, ADDR_CTRL);

  // time base prescaler, postscaler not used here
  pwm_prescaler i_pwm_prescaler (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_run   (tctrl_ff[TCTRL_ON_POS]),
    .i_ps    (tctrl_ff[TCTRL_PS_POS +: 2]),
    .o_tick  (tick),
    .o_fine  (fine)
  ); // [RULE_15] [RULE_08]

  assign restart = tick && (tcount_ff == period_ff); // [RULE_04]
  assign base10  = {tcount_ff, fine};
  assign duty10  = {shadow_ff, lsb_latch_ff}; // [RULE_12] [RULE_01]

  // timer count: wraps to zero after matching period
  always_comb begin
    if (restart) begin
      nxt_tcount = 8'h00; // [RULE_05]
    end else if (tick) begin
      nxt_tcount = tcount_ff + 8'h01;
    end else begin
      nxt_tcount = tcount_ff;
    end
  end

  // timer count register, software may load it
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      tcount_ff <= 8'h00;
    end else if (is_wr(i_req, ADDR_TCOUNT)) begin
      tcount_ff <= i_req.wdata;
    end else begin
      tcount_ff <= nxt_tcount;
    end
  end

  // period and timer control registers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      period_ff <= RST_PERIOD;
      tctrl_ff  <= RST_TCTRL;
    end else begin
      if (is_wr(i_req, ADDR_PERIOD)) begin
        period_ff <= i_req.wdata; // [RULE_04]
      end
      if (is_wr(i_req, ADDR_TCTRL)) begin
        tctrl_ff <= i_req.wdata & TCTRL_MASK;
      end
    end
  end

  // duty low and control registers, writable any time
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      duty_low_ff <= RST_DUTY;
      ctrl_ff     <= RST_CTRL;
    end else begin
      if (is_wr(i_req, ADDR_DUTY_LOW)) begin
        duty_low_ff <= i_req.wdata; // [RULE_10]
      end
      if (wr_ctrl) begin
        ctrl_ff <= i_req.wdata & CTRL_MASK; // [RULE_16]
      end
    end
  end

  // shadow and lsb latch load at pwm period restart; shadow also takes writes outside pwm
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      shadow_ff    <= RST_DUTY;
      lsb_latch_ff <= 2'h0;
    end else if (pwm_mode && restart) begin
      shadow_ff    <= duty_low_ff; // [RULE_07] [RULE_10]
      lsb_latch_ff <= ctrl_ff[CTRL_LSB_POS +: 2]; // [RULE_09]
    end else if (!pwm_mode && is_wr(i_req, ADDR_DUTY_SHADOW)) begin
      shadow_ff    <= i_req.wdata; // [RULE_11] writable outside pwm only
    end
  end

  // output latch
  always_comb begin
    nxt_out = out_ff;
    if (pwm_mode) begin
      if (restart) begin
        // new duty is the one latched at this restart
        nxt_out = ({duty_low_ff, ctrl_ff[CTRL_LSB_POS +: 2]} != 10'h000);
      end else if (duty10 == base10) begin
        nxt_out = 1'b0; // [RULE_13] [RULE_14] unreachable if too long
      end
    end
  end

  // latch register; a zero control write forces it low
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      out_ff <= 1'b0;
    end else if (wr_ctrl && (i_req.wdata == 8'h00)) begin
      out_ff <= 1'b0; // [RULE_03] port data latch is elsewhere
    end else if (!pwm_mode) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out; // [RULE_06]
    end
  end

  // driver enable follows the pin direction bit
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= !i_dir_in; // [RULE_02]
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        ADDR_DUTY_LOW:    rdata_ff <= duty_low_ff;
        ADDR_DUTY_SHADOW: rdata_ff <= shadow_ff;
        ADDR_CTRL:        rdata_ff <= ctrl_ff & CTRL_MASK; // [RULE_16]
        ADDR_PERIOD:      rdata_ff <= period_ff;
        ADDR_TCOUNT:      rdata_ff <= tcount_ff;
        ADDR_TCTRL:       rdata_ff <= tctrl_ff;
        default:          rdata_ff <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign o_rdata  = rdata_ff;
  assign o_pwm    = out_ff;
  assign o_pwm_oe = oe_ff;

endmodule : pwm_channel

// ===== bench/pwm_channel_properties.sv
`timescale 1ns/1ns
// watches the register port and the pin of the channel
module pwm_chk import pwm_pkg::*; (
  input wire logic       i_clock,  // core clock
  input wire logic       i_nrst,   // sync reset, low
  input wire pwm_req_t   i_req,    // register request
  input wire logic       i_dir_in, // pin direction
  input wire logic [7:0] o_rdata,  // read data
  input wire logic       o_pwm,    // output latch
  input wire logic       o_pwm_oe  // driver enable
);
  logic [1:0] mode_ff; // upper mode bits last written
  // follow the mode select that software wrote
  always_ff @(posedge i_clock) begin
    if (!i_nrst) mode_ff <= 2'h0;
    else if (i_req.wr && i_req.addr == ADDR_CTRL) mode_ff <= i_req.wdata[3:2];
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_read_idle_zero: assert property (
    !$past(i_req.rd) |-> o_rdata == 8'h00) else $error("stray read data");
  a_oe_follows_dir: assert property (
    $past(i_nrst) |-> o_pwm_oe == !$past(i_dir_in)) else $error("bad oe");
  a_ctrl_top_zero: assert property (
    i_req.rd && i_req.addr == ADDR_CTRL |=> o_rdata[7:6] == 2'h0)
    else $error("ctrl top bits set");
  a_zero_ctrl_low: assert property (
    i_req.wr && i_req.addr == ADDR_CTRL && i_req.wdata == 8'h00
    |-> ##2 !o_pwm) else $error("pin high after ctrl clear");
  a_unmapped_zero: assert property (
    i_req.rd && i_req.addr > ADDR_TCTRL |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_period_readback: assert property (
    i_req.wr && i_req.addr == ADDR_PERIOD ##1 i_req.rd && i_req.addr ==
    ADDR_PERIOD |=> o_rdata == $past(i_req.wdata, 2)) else $error("period");
  a_duty_lsb_store: assert property (
    i_req.wr && i_req.addr == ADDR_CTRL ##1 i_req.rd && i_req.addr ==
    ADDR_CTRL |=> o_rdata == ($past(i_req.wdata, 2) & CTRL_MASK))
    else $error("ctrl readback");
  a_mode_gates_pin: assert property (
    mode_ff != 2'h3 |=> !o_pwm) else $error("pin high outside pwm mode");
endmodule : pwm_chk
bind pwm_channel pwm_chk i_pwm_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_req(i_req), .i_dir_in(i_dir_in), .o_rdata(o_rdata), .o_pwm(o_pwm),
  .o_pwm_oe(o_pwm_oe));

// ===== bench/pwm_load_model.sv
`timescale 1ns/1ns
// load on the pin: measures high time and period between rising edges
module pwm_load_model (
  input  wire logic       i_clock, // core clock
  input  wire logic       i_nrst,  // sync reset, low
  input  wire logic       i_pwm,   // output latch
  input  wire logic       i_oe,    // driver enable
  output logic      [9:0] o_high,  // high cycles of last period
  output logic      [9:0] o_len    // cycles of last period
);
  logic       pin, last_ff, float_ff; // pin level, history, float pattern
  logic [9:0] hi_ff, len_ff;          // running counts
  // an undriven pin wanders instead of holding its last level
  assign pin = i_oe ? i_pwm : float_ff;
  // count from one rising edge to the next
  always_ff @(posedge i_clock) begin
    float_ff <= i_nrst ? ~float_ff : 1'b0;
    last_ff  <= i_nrst & pin;
    if (!i_nrst) begin
      {o_high, o_len, hi_ff, len_ff} <= '0;
    end else if (pin && !last_ff) begin
      o_high <= hi_ff;
      o_len  <= len_ff;
      hi_ff  <= 10'h001;
      len_ff <= 10'h001;
    end else begin
      hi_ff  <= hi_ff + 10'(pin);
      len_ff <= len_ff + 10'h001;
    end
  end
endmodule : pwm_load_model

// ===== bench/pwm_channel_test.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module pwm_channel_test;
  import pwm_pkg::*;
  logic       i_clock, i_nrst, i_dir_in, o_pwm, o_pwm_oe; // pins
  pwm_req_t   i_req;       // register request
  logic [7:0] o_rdata;     // read data
  logic [9:0] hi, len, h0; // measured times
  int         errors, checks, cyc; // tallies
  pwm_channel i_pwm_channel (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_req(i_req), .i_dir_in(i_dir_in), .o_rdata(o_rdata), .o_pwm(o_pwm),
    .o_pwm_oe(o_pwm_oe));
  pwm_load_model i_pwm_load_model (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_pwm(o_pwm), .i_oe(o_pwm_oe), .o_high(hi), .o_len(len));
  // 100 ns clock and a hang guard
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // one register cycle, strobe left for the next call to replace
  task acc(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    i_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge i_clock);
  endtask : acc
  task wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, 1'b1, a, 8'h00);
    #1 `CHK("rdata", e, o_rdata)
  endtask : rd
  task run(input int n);
    i_req <= '0;
    repeat (n) @(posedge i_clock);
  endtask : run
  task hold(input logic e);
    repeat (40) begin
      @(posedge i_clock);
      `CHK("pin", e, o_pwm)
    end
  endtask : hold
  initial begin
    {i_nrst, i_req, errors, checks, cyc} = '0;
    i_dir_in = 1'b1;
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    rd(ADDR_CTRL, RST_CTRL);
    rd(ADDR_PERIOD, RST_PERIOD);
    rd(ADDR_DUTY_SHADOW, RST_DUTY);
    rd(3'h7, 8'h00);
    wr(ADDR_PERIOD, 8'h09);
    rd(ADDR_PERIOD, 8'h09);
    wr(ADDR_DUTY_LOW, 8'h04);
    wr(ADDR_CTRL, 8'hc0);
    rd(ADDR_CTRL, 8'h00);
    i_dir_in <= 1'b0;
    wr(ADDR_TCTRL, 8'h04);
    wr(ADDR_CTRL, 8'h0c);
    rd(ADDR_CTRL, 8'h0c);
    run(40);
    `CHK("period", 10'd10, len)
    h0 = hi;
    @(posedge o_pwm);
    wr(ADDR_DUTY_LOW, 8'h06);
    rd(ADDR_DUTY_SHADOW, 8'h04);
    run(30);
    rd(ADDR_DUTY_SHADOW, 8'h06);
    `CHK("high step", 10'd2, hi - h0)
    wr(ADDR_DUTY_SHADOW, 8'h55);
    rd(ADDR_DUTY_SHADOW, 8'h06);
    // each prescale ratio, postscaler bits set
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TCTRL, {1'b0, 4'h9, 1'b1, 2'(i)});
      run(35 << (2 * i));
      `CHK("period", 10'(10 << (2 * i)), len)
    end
    wr(ADDR_TCTRL, 8'h05);
    run(140);
    h0 = hi;
    wr(ADDR_CTRL, 8'h2c);
    run(140);
    `CHK("fine step", 10'd2, hi - h0)
    wr(ADDR_DUTY_LOW, 8'h20);
    run(100);
    hold(1'b1);
    wr(ADDR_DUTY_LOW, 8'h00);
    wr(ADDR_CTRL, 8'h0c);
    run(100);
    hold(1'b0);
    wr(ADDR_DUTY_LOW, 8'h20);
    wr(ADDR_CTRL, 8'h0f);
    run(100);
    hold(1'b1);
    wr(ADDR_CTRL, 8'h00);
    run(3);
    hold(1'b0);
    i_dir_in <= 1'b1;
    run(2);
    `CHK("oe", 1'b0, o_pwm_oe)
    final_report();
  end
endmodule : pwm_channel_test
